/* File: shared/alu_exec_regs.svh */
// constants of the rotate, subtract, swap and xor execution datapath
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH

`define DATA_W 8
`define FILE_ADDR_W 7
`define FILE_ADDR_MAX 7'h7F
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define MSB_BIT 7
`define LO_NIB 3:0
`define HI_NIB 7:4
`define ZERO_BYTE 8'h00
`define ACC_RESET 8'h00

`endif

/* File: shared/alu_exec_pkg.sv */
// types of the rotate, subtract, swap and xor execution datapath
`include "alu_exec_regs.svh"

package alu_exec_pkg;

    typedef enum logic [2:0] {
        no_op,
        rotate_right_carry_op,
        literal_minus_accumulator_op,
        file_minus_accumulator_op,
        nibble_exchange_op,
        accumulator_xor_file_op,
        accumulator_xor_literal_op
    } op_t;

    typedef struct packed {
        op_t op;
        logic dest;
        logic [`FILE_ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] literal;
        logic [`DATA_W-1:0] file_data;
    } instr_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_t;

    typedef struct packed {
        logic [`DATA_W-1:0] acc;
        flags_t flags;
        logic file_we;
        logic [`FILE_ADDR_W-1:0] file_addr;
        logic [`DATA_W-1:0] file_wdata;
        logic done;
    } state_t;

endpackage

/* File: hw/alu_exec.sv */
// execution datapath for rotate, subtract, swap and xor instructions
//
// Behaviour
// - rotate right through carry, only carry changes
// - destination bit picks accumulator or file register
// - literal minus accumulator into accumulator, c dc z
// - file minus accumulator to destination, c dc z
// - swap nibbles of file register, no flags
// - file xor accumulator to destination, zero only
// - literal xor accumulator into accumulator, zero only
`timescale 1ns/10ps
`include "alu_exec_regs.svh"

module alu_exec (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // instruction from decoder, one cycle valid strobe
    input wire logic instr_valid,
    input wire alu_exec_pkg::instr_t instr,
    // accumulator and status
    output logic [`DATA_W-1:0] acc,
    output alu_exec_pkg::flags_t flags,
    // file register write-back
    output logic file_we,
    output logic [`FILE_ADDR_W-1:0] file_addr,
    output logic [`DATA_W-1:0] file_wdata,
    // completion pulse
    output logic done
);

    alu_exec_pkg::state_t st_reg;
    alu_exec_pkg::state_t st_next;

    logic [`DATA_W-1:0] result;
    logic [`DATA_W:0] diff;
    logic [4:0] nib_diff;
    logic to_file;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb begin
        st_next = st_reg;
        st_next.file_we = 1'b0;
        st_next.done = 1'b0;
        result = `ZERO_BYTE;
        diff = '0;
        nib_diff = '0;
        to_file = 1'b0;
        if (instr_valid && instr.op != alu_exec_pkg::no_op) begin
            st_next.done = 1'b1;
            case (instr.op)
                alu_exec_pkg::rotate_right_carry_op: begin
                    result = {st_reg.flags.carry, instr.file_data[`MSB_BIT:1]};
                    st_next.flags.carry = instr.file_data[0];
                    to_file = (instr.dest == `DEST_FILE);
                end
                alu_exec_pkg::literal_minus_accumulator_op: begin
                    // borrow-free when no wrap: add inverted operand plus one
                    diff = {1'b0, instr.literal} + {1'b0, ~st_reg.acc} + 9'h001;
                    nib_diff = {1'b0, instr.literal[`LO_NIB]} + {1'b0, ~st_reg.acc[`LO_NIB]} + 5'h01;
                    result = diff[`DATA_W-1:0];
                    st_next.flags.carry = diff[`DATA_W];
                    st_next.flags.digit_carry_flag = nib_diff[4];
                    st_next.flags.zero = (result == `ZERO_BYTE);
                end
                alu_exec_pkg::file_minus_accumulator_op: begin
                    diff = {1'b0, instr.file_data} + {1'b0, ~st_reg.acc} + 9'h001;
                    nib_diff = {1'b0, instr.file_data[`LO_NIB]} + {1'b0, ~st_reg.acc[`LO_NIB]} + 5'h01;
                    result = diff[`DATA_W-1:0];
                    st_next.flags.carry = diff[`DATA_W];
                    st_next.flags.digit_carry_flag = nib_diff[4];
                    st_next.flags.zero = (result == `ZERO_BYTE);
                    to_file = (instr.dest == `DEST_FILE);
                end
                alu_exec_pkg::nibble_exchange_op: begin
                    result = {instr.file_data[`LO_NIB], instr.file_data[`HI_NIB]};
                    to_file = (instr.dest == `DEST_FILE);
                end
                alu_exec_pkg::accumulator_xor_file_op: begin
                    result = st_reg.acc ^ instr.file_data;
                    st_next.flags.zero = (result == `ZERO_BYTE);
                    to_file = (instr.dest == `DEST_FILE);
                end
                alu_exec_pkg::accumulator_xor_literal_op: begin
                    result = st_reg.acc ^ instr.literal;
                    st_next.flags.zero = (result == `ZERO_BYTE);
                end
                default: begin
                    st_next.done = 1'b0;
                end
            endcase
            if (st_next.done) begin
                if (to_file) begin
                    st_next.file_we = 1'b1;
                    st_next.file_addr = instr.addr;
                    st_next.file_wdata = result;
                end else begin
                    st_next.acc = result;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.acc <= `ACC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign acc = st_reg.acc;
    assign flags = st_reg.flags;
    assign file_we = st_reg.file_we;
    assign file_addr = st_reg.file_addr;
    assign file_wdata = st_reg.file_wdata;
    assign done = st_reg.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    rotate_result_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::rotate_right_carry_op |=>
        flags.carry == $past(instr.file_data[0]) && flags.zero == $past(flags.zero)
        && flags.digit_carry_flag == $past(flags.digit_carry_flag))
        else $error("rotate carry or flags wrong");

    dest_select_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::nibble_exchange_op |=>
        file_we == $past(instr.dest) && (file_we || acc == {$past(instr.file_data[3:0]), $past(instr.file_data[7:4])}))
        else $error("destination select wrong");

    lit_sub_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::literal_minus_accumulator_op |=>
        acc == 8'($past(instr.literal) - $past(acc)) && flags.carry == ($past(instr.literal) >= $past(acc)))
        else $error("literal subtract wrong");

    file_sub_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::file_minus_accumulator_op && instr.dest == `DEST_FILE |=>
        file_we && file_wdata == 8'($past(instr.file_data) - $past(acc)) && acc == $past(acc))
        else $error("file subtract wrong");

    swap_flags_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::nibble_exchange_op |=> flags == $past(flags))
        else $error("swap changed flags");

    xor_file_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::accumulator_xor_file_op |=>
        flags.carry == $past(flags.carry) && flags.zero == (($past(acc) ^ $past(instr.file_data)) == 8'h00))
        else $error("file xor wrong");

    xor_lit_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::accumulator_xor_literal_op |=>
        !file_we && acc == ($past(acc) ^ $past(instr.literal)))
        else $error("literal xor wrong");

    zero_flag_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::literal_minus_accumulator_op |=>
        flags.zero == (acc == 8'h00) && flags.digit_carry_flag == ($past(instr.literal[3:0]) >= $past(acc[3:0])))
        else $error("zero or digit carry wrong");

    file_sub_flags_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::file_minus_accumulator_op |=>
        flags.carry == ($past(instr.file_data) >= $past(acc))
        && flags.digit_carry_flag == ($past(instr.file_data[3:0]) >= $past(acc[3:0]))
        && flags.zero == ($past(instr.file_data) == $past(acc)))
        else $error("file subtract flags wrong");

    file_sub_acc_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::file_minus_accumulator_op && instr.dest == `DEST_ACC |=>
        !file_we && acc == 8'($past(instr.file_data) - $past(acc)))
        else $error("file subtract to accumulator wrong");

    rotate_file_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::rotate_right_carry_op && instr.dest == `DEST_FILE |=>
        file_we && file_addr == $past(instr.addr) && acc == $past(acc)
        && file_wdata == {$past(flags.carry), $past(instr.file_data[7:1])})
        else $error("rotate to file wrong");

    rotate_acc_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::rotate_right_carry_op && instr.dest == `DEST_ACC |=>
        !file_we && acc == {$past(flags.carry), $past(instr.file_data[7:1])})
        else $error("rotate to accumulator wrong");

    swap_file_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::nibble_exchange_op && instr.dest == `DEST_FILE |=>
        file_wdata == {$past(instr.file_data[3:0]), $past(instr.file_data[7:4])} && acc == $past(acc))
        else $error("swap to file wrong");

    xor_file_dest_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::accumulator_xor_file_op && instr.dest == `DEST_FILE |=>
        file_we && file_wdata == ($past(acc) ^ $past(instr.file_data))
        && flags.digit_carry_flag == $past(flags.digit_carry_flag) && acc == $past(acc))
        else $error("file xor to file wrong");

    xor_file_acc_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::accumulator_xor_file_op && instr.dest == `DEST_ACC |=>
        !file_we && acc == ($past(acc) ^ $past(instr.file_data)))
        else $error("file xor to accumulator wrong");

    xor_lit_flags_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op == alu_exec_pkg::accumulator_xor_literal_op |=>
        flags.carry == $past(flags.carry) && flags.digit_carry_flag == $past(flags.digit_carry_flag)
        && flags.zero == (acc == 8'h00))
        else $error("literal xor flags wrong");

    exec_done_a: assert property (@(posedge clk) disable iff (srst)
        instr_valid && instr.op != alu_exec_pkg::no_op |=> done)
        else $error("done missing");

    idle_hold_a: assert property (@(posedge clk) disable iff (srst)
        !instr_valid || instr.op == alu_exec_pkg::no_op |=>
        !done && !file_we && acc == $past(acc) && flags == $past(flags))
        else $error("idle cycle changed state");

endmodule

/* File: bench/file_mem_model.sv */
// file register memory beside the execution datapath
`timescale 1ns/10ps
`include "alu_exec_regs.svh"

module file_mem_model (
    // clock
    input wire logic clk,
    // operand read
    input wire logic [`FILE_ADDR_W-1:0] rd_addr,
    output logic [`DATA_W-1:0] rd_data,
    // write-back
    input wire logic we,
    input wire logic [`FILE_ADDR_W-1:0] wr_addr,
    input wire logic [`DATA_W-1:0] wr_data
);
    logic [`DATA_W-1:0] mem [0:127];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 8'h25 + 8'h5A);
        end
    end
    // operand of the addressed register in the same cycle
    assign rd_data = mem[rd_addr];
    always @(posedge clk) begin
        if (we) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

/* File: bench/alu_exec_tb.sv */
// self-checking bench of the execution datapath
`timescale 1ns/10ps
`include "alu_exec_regs.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end

module alu_exec_tb;
    localparam alu_exec_pkg::op_t rot = alu_exec_pkg::rotate_right_carry_op;
    localparam alu_exec_pkg::op_t lsub = alu_exec_pkg::literal_minus_accumulator_op;
    localparam alu_exec_pkg::op_t fsub = alu_exec_pkg::file_minus_accumulator_op;
    localparam alu_exec_pkg::op_t swp = alu_exec_pkg::nibble_exchange_op;
    localparam alu_exec_pkg::op_t xorf = alu_exec_pkg::accumulator_xor_file_op;
    localparam alu_exec_pkg::op_t xorl = alu_exec_pkg::accumulator_xor_literal_op;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic instr_valid = 1'h0;
    alu_exec_pkg::op_t op = alu_exec_pkg::no_op;
    logic dest = 1'h0;
    logic [6:0] addr = 7'h00;
    logic [7:0] lit = 8'h00;
    logic [7:0] fdata, acc, file_wdata, e_acc;
    alu_exec_pkg::instr_t instr;
    alu_exec_pkg::flags_t flags, e_fl;
    logic file_we, done;
    logic [6:0] file_addr;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;

    assign instr = {op, dest, addr, lit, fdata};
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    alu_exec alu_exec_inst (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr), .acc(acc),
        .flags(flags), .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata), .done(done));
    file_mem_model file_mem_model_inst (.clk(clk), .rd_addr(addr), .rd_data(fdata), .we(file_we),
        .wr_addr(file_addr), .wr_data(file_wdata));

    task automatic exec(input alu_exec_pkg::op_t o, input logic d, input logic [6:0] a, input logic [7:0] k);
        logic [7:0] s, r;
        logic wf;
        op = o; dest = d; addr = a; lit = k; instr_valid = 1'h1;
        #1;
        s = (o == lsub || o == xorl) ? k : fdata;
        wf = d && o != lsub && o != xorl;
        case (o)
            rot: begin r = {e_fl.carry, s[7:1]}; e_fl.carry = s[0]; end
            lsub, fsub: begin r = s - e_acc; e_fl = {s >= e_acc, s[3:0] >= e_acc[3:0], r == 8'h00}; end
            swp: r = {s[3:0], s[7:4]};
            default: begin r = s ^ e_acc; e_fl.zero = (r == 8'h00); end
        endcase
        if (!wf) e_acc = r;
        @(posedge clk); #1;
        `CHK("acc", e_acc, acc)
        `CHK("flags", e_fl, flags)
        `CHK("file_we", wf, file_we)
        `CHK("done", 1'h1, done)
        if (wf) begin
            `CHK("file_addr", a, file_addr)
            `CHK("file_wdata", r, file_wdata)
        end
    endtask

    task automatic idle;
        op = alu_exec_pkg::no_op;
        @(posedge clk); #1;
        `CHK("idle done", 1'h0, done)
        `CHK("idle file_we", 1'h0, file_we)
        `CHK("idle acc", e_acc, acc)
        instr_valid = 1'h0;
        op = swp;
        @(posedge clk); #1;
        `CHK("gated done", 1'h0, done)
        `CHK("gated file_we", 1'h0, file_we)
        `CHK("gated acc", e_acc, acc)
    endtask

    task automatic t_reset(input int n);
        srst = 1'h1; instr_valid = 1'h0;
        repeat (n) @(posedge clk);
        #1 srst = 1'h0;
        e_acc = 8'h00; e_fl = 3'h0;
        `CHK("reset acc", e_acc, acc)
        `CHK("reset flags", e_fl, flags)
        `CHK("reset done", 1'h0, done)
        $display("test reset done");
    endtask

    task automatic t_literal;
        exec(xorl, 1'h0, 7'h00, 8'h3C);
        exec(xorl, 1'h1, 7'h05, 8'h3C);
        exec(lsub, 1'h0, 7'h00, 8'h00);
        exec(lsub, 1'h0, 7'h00, 8'h25);
        exec(lsub, 1'h1, 7'h06, 8'h13);
        exec(lsub, 1'h0, 7'h00, 8'hF0);
        idle();
        $display("test literal done");
    endtask

    task automatic t_file;
        exec(rot, 1'h0, 7'h10, 8'h00);
        exec(rot, 1'h1, 7'h20, 8'h00);
        exec(rot, 1'h1, 7'h13, 8'h00);
        exec(fsub, 1'h1, 7'h7F, 8'h00);
        exec(fsub, 1'h0, 7'h30, 8'h00);
        exec(swp, 1'h0, 7'h11, 8'h00);
        exec(swp, 1'h1, 7'h21, 8'h00);
        exec(xorf, 1'h1, 7'h31, 8'h00);
        exec(xorf, 1'h0, 7'h32, 8'h00);
        exec(xorf, 1'h0, 7'h32, 8'h00);
        idle();
        exec(swp, 1'h0, 7'h21, 8'h00);
        idle();
        $display("test file done");
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        t_reset(16);
        t_literal();
        t_file();
        t_reset(1);
        t_literal();
        report_and_stop();
    end
endmodule
